// ### hw/cpu_transfer_trap_exec.sv
// executor for trap, register transfer, test and wait instructions
// Notes on behaviour
// - trap stacks return address, index low, acc, flags; sets mask; vectors; eleven cycles.
// - acc-to-flags copies accumulator into the condition code byte, with the fixed-one bits forced set, in one cycle.
// - acc-to-index-low copies accumulator into index low byte, flags untouched.
// - flags-to-acc copies condition code byte into accumulator, flags untouched.
// - test subtracts zero, sets negative and zero, clears overflow, discards result.
// - stackptr-to-index loads index with stack pointer plus one, free then fetch.
// - index-low-to-acc copies index low byte into accumulator, flags untouched.
// - index-to-stackptr loads stack pointer with index minus one in two cycles.
// - wait clears the mask, runs a free cycle and a fetch, then halts.
// - a free cycle lasts one clock, does no useful work, and is a read.
// - vectors are read from the top page, high byte first.
// - each push writes one stack byte, then the stack pointer drops by one.
// - each pop reads a single byte from the stack.
// - a program fetch reads the next sequential program location.
// - relative targets are signed byte offsets from the following instruction.
// - direct operands address page zero with upper address byte zero.
`timescale 1ns/1ps
module cpu_transfer_trap_exec (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic irqReq,
    input wire logic [7:0] busRdata,
    output logic [15:0] busAddr,
    output logic [7:0] busWdata,
    output logic busRead,
    output cpu_exec_pkg::busCycle_t busCycle,
    output logic halted,
    output logic [7:0] accOut,
    output logic [15:0] indexOut,
    output logic [15:0] stackPtrOut,
    output logic [15:0] progCounterOut,
    output logic [7:0] ccrOut
);
    import cpu_exec_pkg::*;

    logic [1:0] rstPipe_reg;
    logic rstSync_b;
    state_t state_reg, state_next;
    logic [7:0] op_reg, acc_reg, ccr_reg, dir_reg, vecLo_reg;
    logic [15:0] pc_reg, index_reg, stack_pointer_reg, retPc_reg;
    logic [2:0] pushCnt_reg;
    logic [1:0] fillCnt_reg;
    flag_eval_if fe ();

    // reset enters asynchronously but is released through two flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_reg <= 2'b00;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'b1};
        end
    end
    assign rstSync_b = rstPipe_reg[1];

    // decode
    wire inExec = (state_reg == ST_EXEC);
    wire irqTake = irqReq && !ccr_reg[CCR_I];
    wire execTrap = inExec && !irqTake && (op_reg == OP_TRAP);
    wire trapStart = inExec && (irqTake || op_reg == OP_TRAP);
    wire execRun = inExec && !trapStart;
    wire isXferFree = (op_reg == OP_STACKPTR_TO_INDEX) || (op_reg == OP_INDEX_TO_STACKPTR);
    wire isFreeFirst = isXferFree || (op_reg == OP_WAIT);
    wire execFetch = execRun && !isFreeFirst;
    wire wake = (state_reg == ST_HALT) && irqTake;
    wire isPush = (state_reg == ST_PUSH) || trapStart;
    wire [2:0] pushIdx = inExec ? 3'h0 : pushCnt_reg;
    wire isVector = (state_reg == ST_VEC_HI) || (state_reg == ST_VEC_LO) ||
        (state_reg == ST_RST_VH) || (state_reg == ST_RST_VL);
    wire vecHigh = (state_reg == ST_VEC_HI) || (state_reg == ST_RST_VH);
    wire isTstRead = (state_reg == ST_TST_READ);
    wire isFree = (execRun && isFreeFirst) || (state_reg == ST_TST_FREE) ||
        (state_reg == ST_BRA_FREE) || (state_reg == ST_FILL_FREE) || (state_reg == ST_HALT);
    // the fill fetches re-read the new start address; only the last one takes the opcode
    wire seqFetch = execFetch || (state_reg == ST_REFETCH) || (state_reg == ST_WAIT_FETCH);
    wire [15:0] relTarget = pc_reg + {{8{dir_reg[7]}}, dir_reg};
    wire [7:0] vecLoNow = vecHigh ? vecLo_reg : vecLo_reg + 8'h01;
    wire [7:0] vecSel = (state_reg == ST_RST_VH || state_reg == ST_RST_VL) ? VEC_RESET_LO : vecLo_reg;
    wire [7:0] vecAddrLo = vecHigh ? vecSel : vecSel + 8'h01;
    wire [15:0] trapRet = execTrap ? pc_reg : pc_reg - 16'h0001;
    wire [15:0] pushRet = inExec ? trapRet : retPc_reg;
    wire [7:0] tstOperand = (op_reg == OP_TEST_ACC) ? acc_reg :
        (op_reg == OP_TEST_INDEX) ? index_reg[7:0] : busRdata;

    assign fe.operand = tstOperand;
    assign fe.ccrIn = ccr_reg;

    test_flag_unit flagUnit (
        .fe(fe.unit)
    );

    // bus cycle kind, address and write data
    assign busCycle = isPush ? CYC_S : isVector ? CYC_V : isTstRead ? CYC_R : isFree ? CYC_F : CYC_P;
    assign busRead = !isPush;
    assign busAddr = isPush ? stack_pointer_reg :
        isVector ? {VECTOR_PAGE, vecAddrLo} :
        isTstRead ? {DIRECT_PAGE, dir_reg} : pc_reg;
    always_comb begin
        unique case (pushIdx)
            3'h0: busWdata = pushRet[7:0];
            3'h1: busWdata = retPc_reg[15:8];
            3'h2: busWdata = index_reg[7:0];
            3'h3: busWdata = acc_reg;
            default: busWdata = ccr_reg;
        endcase
    end

    // sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RST_VH: state_next = ST_RST_VL;
            ST_RST_VL: state_next = ST_REFETCH;
            ST_EXEC: begin
                if (trapStart) begin
                    state_next = ST_PUSH;
                end else if (isXferFree) begin
                    state_next = ST_REFETCH;
                end else if (op_reg == OP_WAIT) begin
                    state_next = ST_WAIT_FETCH;
                end else if (op_reg == OP_TEST_DIRECT) begin
                    state_next = ST_TST_READ;
                end else if (op_reg == OP_BRANCH_ALWAYS) begin
                    state_next = ST_BRA_FREE;
                end
            end
            ST_REFETCH: state_next = ST_EXEC;
            ST_TST_READ: state_next = ST_TST_FREE;
            ST_TST_FREE: state_next = ST_REFETCH;
            ST_BRA_FREE: state_next = ST_REFETCH;
            ST_WAIT_FETCH: state_next = ST_HALT;
            ST_HALT: state_next = wake ? ST_PUSH : ST_HALT;
            ST_PUSH: state_next = (pushCnt_reg == PUSH_LAST) ? ST_VEC_HI : ST_PUSH;
            ST_VEC_HI: state_next = ST_VEC_LO;
            ST_VEC_LO: state_next = ST_FILL_FREE;
            ST_FILL_FREE: state_next = ST_FILL;
            ST_FILL: state_next = (fillCnt_reg == FILL_LAST) ? ST_REFETCH : ST_FILL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_reg <= ST_RST_VH;
            pushCnt_reg <= 3'h0;
            fillCnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            pushCnt_reg <= (isPush && state_reg == ST_PUSH) ? pushCnt_reg + 3'h1 : (trapStart ? 3'h1 : 3'h0);
            fillCnt_reg <= (state_reg == ST_FILL) ? fillCnt_reg + 2'h1 : 2'h0;
        end
    end

    // program counter, opcode and operand latches
    always_ff @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            pc_reg <= 16'h0000;
            op_reg <= 8'h00;
            dir_reg <= 8'h00;
            retPc_reg <= 16'h0000;
            vecLo_reg <= VEC_TRAP_LO;
        end else begin
            if (seqFetch) begin
                pc_reg <= pc_reg + 16'h0001;
            end else if (vecHigh) begin
                pc_reg[15:8] <= busRdata;
            end else if (isVector) begin
                pc_reg[7:0] <= busRdata;
            end else if (state_reg == ST_BRA_FREE) begin
                pc_reg <= relTarget;
            end
            if (seqFetch && !(execFetch && (op_reg == OP_TEST_DIRECT || op_reg == OP_BRANCH_ALWAYS))) begin
                op_reg <= busRdata;
            end else if (execFetch) begin
                op_reg <= 8'h00;
                dir_reg <= busRdata;
            end
            if (trapStart) begin
                retPc_reg <= trapRet;
                vecLo_reg <= execTrap ? VEC_TRAP_LO : VEC_IRQ_LO;
            end else if (wake) begin
                retPc_reg <= pc_reg - 16'h0001;
                vecLo_reg <= VEC_IRQ_LO;
            end
        end
    end

    // architectural registers
    always_ff @(posedge sys_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            acc_reg <= 8'h00;
            index_reg <= 16'h0000;
            stack_pointer_reg <= SP_RESET;
            ccr_reg <= CCR_RESET;
        end else begin
            if (isPush) begin
                stack_pointer_reg <= stack_pointer_reg - 16'h0001;
            end else if (execRun && op_reg == OP_INDEX_TO_STACKPTR) begin
                stack_pointer_reg <= index_reg - 16'h0001;
            end
            if (execRun && op_reg == OP_ACC_TO_INDEX_LOW) begin
                index_reg[7:0] <= acc_reg;
            end else if (execRun && op_reg == OP_STACKPTR_TO_INDEX) begin
                index_reg <= stack_pointer_reg + 16'h0001;
            end
            if (execRun && op_reg == OP_FLAGS_TO_ACC) begin
                acc_reg <= ccr_reg;
            end else if (execRun && op_reg == OP_INDEX_LOW_TO_ACC) begin
                acc_reg <= index_reg[7:0];
            end
            if (execRun && op_reg == OP_ACC_TO_FLAGS) begin
                ccr_reg <= acc_reg | CCR_FIXED_ONES;
            end else if (execRun && (op_reg == OP_TEST_ACC || op_reg == OP_TEST_INDEX)) begin
                ccr_reg <= fe.ccrOut;
            end else if (isTstRead) begin
                ccr_reg <= fe.ccrOut;
            end else if (execRun && op_reg == OP_WAIT) begin
                ccr_reg[CCR_I] <= 1'b0;
            end else if (state_reg == ST_VEC_HI) begin
                ccr_reg[CCR_I] <= 1'b1;
            end
        end
    end

    assign halted = (state_reg == ST_HALT);
    assign accOut = acc_reg;
    assign indexOut = index_reg;
    assign stackPtrOut = stack_pointer_reg;
    assign progCounterOut = pc_reg;
    assign ccrOut = ccr_reg;

    // checks
    trap_sequence_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execTrap |-> (busCycle == CYC_S)[*5] ##1 (busCycle == CYC_V)[*2] ##1 busCycle == CYC_F
        ##1 (busCycle == CYC_P)[*3] ##1 ccr_reg[CCR_I]) else $error("trap sequence wrong");
    acc_flags_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_ACC_TO_FLAGS |=> ccr_reg == ($past(acc_reg) | CCR_FIXED_ONES))
        else $error("acc to flags copy wrong");
    acc_index_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_ACC_TO_INDEX_LOW |=> index_reg[7:0] == $past(acc_reg) && $stable(ccr_reg))
        else $error("acc to index low wrong");
    flags_acc_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_FLAGS_TO_ACC |=> acc_reg == $past(ccr_reg) && $stable(ccr_reg))
        else $error("flags to acc wrong");
    test_flags_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_TEST_ACC |=> ccr_reg[CCR_Z] == ($past(acc_reg) == 8'h00)
        && ccr_reg[CCR_N] == $past(acc_reg[7]) && !ccr_reg[CCR_V] && $stable(acc_reg))
        else $error("test flags wrong");
    sp_index_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_STACKPTR_TO_INDEX |-> busCycle == CYC_F
        ##1 busCycle == CYC_P && index_reg == stack_pointer_reg + 16'h0001)
        else $error("stack to index wrong");
    index_acc_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_INDEX_LOW_TO_ACC |=> acc_reg == $past(index_reg[7:0]) && $stable(ccr_reg))
        else $error("index low to acc wrong");
    index_sp_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_INDEX_TO_STACKPTR |=> stack_pointer_reg == $past(index_reg) - 16'h0001
        && $stable(ccr_reg)) else $error("index to stack wrong");
    wait_halt_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_WAIT |-> busCycle == CYC_F ##1 busCycle == CYC_P ##1 halted && !ccr_reg[CCR_I])
        else $error("wait sequence wrong");
    free_read_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        busCycle == CYC_F |-> busRead) else $error("free cycle not a read");
    vector_page_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        state_reg == ST_VEC_HI |-> busAddr == {VECTOR_PAGE, vecLo_reg}
        ##1 busAddr == {VECTOR_PAGE, vecLoNow}) else $error("vector address wrong");
    push_step_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        busCycle == CYC_S |-> !busRead ##1 stack_pointer_reg == $past(stack_pointer_reg) - 16'h0001)
        else $error("push step wrong");
    fetch_next_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        seqFetch |=> pc_reg == $past(pc_reg) + 16'h0001) else $error("fetch not sequential");
    branch_rel_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        state_reg == ST_BRA_FREE |=> busAddr == $past(relTarget)) else $error("branch target wrong");
    direct_page_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        isTstRead |-> busAddr[15:8] == DIRECT_PAGE) else $error("direct read off page zero");
    wake_stack_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        wake |=> busCycle == CYC_S && busWdata == $past(pc_reg[7:0]) - 8'h01)
        else $error("wake did not stack");
    // flags of a direct test come from the byte just read
    test_direct_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        isTstRead |=> ccr_reg[CCR_Z] == ($past(busRdata) == 8'h00) && ccr_reg[CCR_N] == $past(busRdata[7])
        && !ccr_reg[CCR_V]) else $error("direct test flags wrong");
    test_index_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        execRun && op_reg == OP_TEST_INDEX |=> ccr_reg[CCR_Z] == ($past(index_reg[7:0]) == 8'h00)
        && ccr_reg[CCR_N] == $past(index_reg[7]) && !ccr_reg[CCR_V]) else $error("index test flags wrong");
    // nothing here pops; a pop would have to be a plain one-byte read
    no_pop_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        busCycle != CYC_U) else $error("unexpected pop cycle");
    // an interrupt taken in flight stacks the address of the opcode it displaced
    irq_stack_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        trapStart && !execTrap |-> busCycle == CYC_S && busWdata == pc_reg[7:0] - 8'h01
        ##5 busAddr == {VECTOR_PAGE, VEC_IRQ_LO}) else $error("interrupt entry wrong");
    // halted, the core idles on free reads at the program counter, one past the resume address
    halt_free_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        halted |-> busCycle == CYC_F && busAddr == pc_reg) else $error("halt not idle");
    ccr_fixed_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        (ccr_reg & CCR_FIXED_ONES) == CCR_FIXED_ONES) else $error("fixed flag bits lost");
    reset_vector_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        state_reg == ST_RST_VH |-> busCycle == CYC_V && busAddr == {VECTOR_PAGE, VEC_RESET_LO}) else $error("reset vector wrong");
    trap_mask_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        state_reg == ST_VEC_HI |=> ccr_reg[CCR_I]) else $error("mask not set on vector");
    fill_addr_a: assert property (@(posedge sys_clk) disable iff (!rstSync_b)
        state_reg == ST_FILL |-> busCycle == CYC_P && busAddr == pc_reg) else $error("fill fetch wrong");
endmodule // cpu_transfer_trap_exec

// ### hw/cpu_exec_pkg.sv
// constants and types shared by the transfer, trap and wait executor
package cpu_exec_pkg;
    // opcodes handled by this executor
    localparam logic [7:0] OP_TRAP = 8'h83;
    localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h84;
    localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h85;
    localparam logic [7:0] OP_ACC_TO_INDEX_LOW = 8'h97;
    localparam logic [7:0] OP_INDEX_LOW_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_STACKPTR_TO_INDEX = 8'h95;
    localparam logic [7:0] OP_INDEX_TO_STACKPTR = 8'h94;
    localparam logic [7:0] OP_TEST_DIRECT = 8'h3D;
    localparam logic [7:0] OP_TEST_ACC = 8'h4D;
    localparam logic [7:0] OP_TEST_INDEX = 8'h5D;
    localparam logic [7:0] OP_WAIT = 8'h8F;
    localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
    // condition code byte layout
    localparam int CCR_V = 7;
    localparam int CCR_H = 4;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0] CCR_FIXED_ONES = 8'h60;
    localparam logic [7:0] CCR_RESET = 8'h68;
    // vectors live in the top page, high byte at the lower address
    localparam logic [7:0] VECTOR_PAGE = 8'hFF;
    localparam logic [7:0] VEC_RESET_LO = 8'hFE;
    localparam logic [7:0] VEC_TRAP_LO = 8'hFC;
    localparam logic [7:0] VEC_IRQ_LO = 8'hFA;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [2:0] PUSH_LAST = 3'h4;
    localparam logic [1:0] FILL_LAST = 2'h1;

    typedef enum logic [2:0] {
        CYC_P, CYC_R, CYC_W, CYC_S, CYC_U, CYC_V, CYC_F
    } busCycle_t;

    typedef enum {
        ST_RST_VH, ST_RST_VL, ST_EXEC, ST_REFETCH, ST_TST_READ, ST_TST_FREE, ST_BRA_FREE,
        ST_WAIT_FETCH, ST_HALT, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_FILL_FREE, ST_FILL
    } state_t;
endpackage

// ### hw/flag_eval_if.sv
// carrier between the executor and its test-flag unit
`timescale 1ns/1ps
interface flag_eval_if;
    logic [7:0] operand;
    logic [7:0] ccrIn;
    logic [7:0] ccrOut;
    modport user (output operand, output ccrIn, input ccrOut);
    modport unit (input operand, input ccrIn, output ccrOut);
endinterface

// ### hw/test_flag_unit.sv
// flag result of subtracting zero from an operand
`timescale 1ns/1ps
module test_flag_unit (
    flag_eval_if.unit fe
);
    import cpu_exec_pkg::*;

    // operand minus zero is the operand itself, so no subtractor is needed
    wire resNeg = fe.operand[7];
    wire resZero = (fe.operand == 8'h00);

    always_comb begin
        fe.ccrOut = fe.ccrIn;
        fe.ccrOut[CCR_N] = resNeg;
        fe.ccrOut[CCR_Z] = resZero;
        fe.ccrOut[CCR_V] = 1'b0;
    end
endmodule // test_flag_unit

// ### tb/sys_memory_model.sv
// zero-wait memory serving program, data, stack and vector cycles
`timescale 1ns/1ps
module sys_memory_model (
    input wire logic sys_clk,
    input wire logic [15:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busRead,
    output logic [7:0] busRdata
);
    logic [7:0] cells [0:65535];
    logic [7:0] lastRead = 8'h00;
    // write cycles leave the data line floating: show the inverse so a stale value cannot pass
    assign busRdata = busRead ? cells[busAddr] : ~lastRead;
    always @(posedge sys_clk) begin
        if (busRead) begin
            lastRead <= cells[busAddr];
        end else begin
            cells[busAddr] <= busWdata;
        end
    end
endmodule // sys_memory_model

// ### tb/test_cpu_transfer_trap_instr_exec.sv
// self-checking bench for the transfer, trap and wait executor
`timescale 1ns/1ps
module test_cpu_transfer_trap_instr_exec;
    import cpu_exec_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic irqReq = 1'b0;
    logic [7:0] busRdata;
    logic [15:0] busAddr;
    logic [7:0] busWdata;
    logic busRead;
    busCycle_t busCycle;
    logic halted;
    logic [7:0] accOut;
    logic [15:0] indexOut;
    logic [15:0] stackPtrOut;
    logic [15:0] progCounterOut;
    logic [7:0] ccrOut;
    int mismatches = 0;
    int samples_checked = 0;
    bit traceOn = 1'b0;
    int traceCount = 0;
    busCycle_t cycTrace [512];
    logic [15:0] addrTrace [512];
    logic [7:0] dataTrace [512];
    logic readTrace [512];

    cpu_transfer_trap_exec uut (.sys_clk(sys_clk), .rst_b(rst_b), .irqReq(irqReq), .busRdata(busRdata),
        .busAddr(busAddr), .busWdata(busWdata), .busRead(busRead), .busCycle(busCycle), .halted(halted),
        .accOut(accOut), .indexOut(indexOut), .stackPtrOut(stackPtrOut), .progCounterOut(progCounterOut),
        .ccrOut(ccrOut));
    sys_memory_model memModel (.sys_clk(sys_clk), .busAddr(busAddr), .busWdata(busWdata), .busRead(busRead),
        .busRdata(busRdata));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (traceOn && traceCount < 512) begin
            cycTrace[traceCount] <= busCycle;
            addrTrace[traceCount] <= busAddr;
            dataTrace[traceCount] <= busWdata;
            readTrace[traceCount] <= busRead;
            traceCount <= traceCount + 1;
        end
    end

    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkCycle(input busCycle_t got, input busCycle_t exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s: got %s expected %s", $time, what, got.name(), exp.name());
        end
    endtask

    task automatic loadProg(input logic [15:0] base, input logic [7:0] prog [$]);
        foreach (prog[i]) memModel.cells[base + i] = prog[i];
    endtask

    // fresh memory and a full reset per scenario keeps the scenarios independent
    task automatic startRun(input int cycles);
        traceOn = 1'b0;
        rst_b = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        traceCount = 0;
        rst_b = 1'b1;
        traceOn = 1'b1;
        repeat (cycles) @(posedge sys_clk);
        #1;
    endtask

    task automatic clearMem();
        for (int i = 0; i < 65536; i++) memModel.cells[i] = 8'h00;
        loadProg(16'hFFFA, '{8'h03, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00});
    endtask

    function automatic int findIdx(input busCycle_t c, input logic [15:0] a);
        for (int i = 0; i < traceCount; i++) begin
            if (cycTrace[i] === c && addrTrace[i] === a) return i;
        end
        return -1;
    endfunction

    task automatic checkRegs(input logic [7:0] a, input logic [15:0] x, input logic [15:0] s, input logic [7:0] c);
        checkVal(16'(accOut), 16'(a), "accumulator");
        checkVal(indexOut, x, "index");
        checkVal(stackPtrOut, s, "stack pointer");
        checkVal(16'(ccrOut), 16'(c), "flags");
        checkVal(16'(halted), 16'h0001, "halted");
    endtask

    task automatic checkStack(input int t, input logic [15:0] ret, input logic [7:0] a, input logic [7:0] cc,
        input logic [7:0] vlo, input logic [15:0] target);
        logic [7:0] wd [5];
        wd = '{ret[7:0], ret[15:8], 8'h00, a, cc};
        for (int i = 0; i < 5; i++) begin
            checkCycle(cycTrace[t + i], CYC_S, "push kind");
            checkVal(addrTrace[t + i], 16'h00FF - 16'(i), "push address");
            checkVal(16'(dataTrace[t + i]), 16'(wd[i]), "push data");
        end
        checkCycle(cycTrace[t + 5], CYC_V, "vector high kind");
        checkVal(addrTrace[t + 5], {VECTOR_PAGE, vlo}, "vector high address");
        checkCycle(cycTrace[t + 6], CYC_V, "vector low kind");
        checkVal(addrTrace[t + 6], {VECTOR_PAGE, vlo + 8'h01}, "vector low address");
        checkCycle(cycTrace[t + 7], CYC_F, "free kind");
        for (int i = 8; i < 11; i++) begin
            checkCycle(cycTrace[t + i], CYC_P, "refill kind");
            checkVal(addrTrace[t + i], target, "refill address");
        end
    endtask

    // only push cycles may write; every other kind, free cycles included, is a read
    task automatic endTest(input string name);
        int bad;
        bad = 0;
        for (int i = 0; i < traceCount; i++) begin
            if (readTrace[i] !== (cycTrace[i] != CYC_S)) bad++;
        end
        checkVal(16'(bad), 16'h0000, "read level per cycle kind");
        $display("test %s done", name);
    endtask

    task automatic testCopies();
        int p;
        clearMem();
        loadProg(16'h0100, '{8'h85, 8'h97, 8'h8F});
        startRun(30);
        p = findIdx(CYC_P, 16'h0100);
        checkVal(addrTrace[p + 1], 16'h0101, "second fetch");
        checkVal(addrTrace[p + 2], 16'h0102, "third fetch");
        checkCycle(cycTrace[p + 3], CYC_F, "wait free cycle");
        checkCycle(cycTrace[p + 4], CYC_P, "wait fetch");
        checkRegs(8'h68, 16'h0068, 16'h00FF, 8'h60);
        endTest("copies");
    endtask

    task automatic testFlagsLoad();
        clearMem();
        loadProg(16'h0010, '{8'h80, 8'h00});
        loadProg(16'h0100, '{8'h3D, 8'h10, 8'h85, 8'h3D, 8'h11, 8'h84, 8'h4D, 8'h8F});
        startRun(40);
        checkVal(16'(findIdx(CYC_R, 16'h0010) >= 0), 16'h0001, "direct read page zero");
        checkVal(16'(findIdx(CYC_R, 16'h0011) >= 0), 16'h0001, "second direct read");
        checkRegs(8'h6C, 16'h0000, 16'h00FF, 8'h60);
        endTest("flags load");
    endtask

    task automatic testStackIndex();
        clearMem();
        loadProg(16'h0011, '{8'h00});
        loadProg(16'h0100, '{8'h85, 8'h97, 8'h94, 8'h3D, 8'h11, 8'h85, 8'h97, 8'h95, 8'h9F, 8'h5D, 8'h8F});
        startRun(50);
        checkRegs(8'h68, 16'h0068, 16'h0067, 8'h60);
        endTest("stack index");
    endtask

    task automatic testTrap();
        int p;
        int t;
        clearMem();
        loadProg(16'h0100, '{8'h85, 8'h83});
        loadProg(16'h0200, '{8'h85, 8'h8F});
        startRun(40);
        p = findIdx(CYC_P, 16'h0100);
        t = findIdx(CYC_S, 16'h00FF);
        checkVal(16'(t - p), 16'h0002, "trap start");
        checkStack(t, 16'h0102, 8'h68, 8'h68, VEC_TRAP_LO, 16'h0200);
        checkRegs(8'h68, 16'h0000, 16'h00FA, 8'h60);
        endTest("trap");
    endtask

    task automatic testWaitWake();
        int t;
        clearMem();
        loadProg(16'h0100, '{8'h8F});
        loadProg(16'h0300, '{8'h85, 8'h8F});
        startRun(20);
        checkVal(16'(halted), 16'h0001, "halted before wake");
        checkVal(16'(ccrOut), 16'h0060, "mask cleared by wait");
        checkCycle(busCycle, CYC_F, "halted bus kind");
        irqReq = 1'b1;
        for (int i = 0; i < 10 && busCycle !== CYC_S; i++) begin
            @(posedge sys_clk);
            #1;
        end
        checkCycle(busCycle, CYC_S, "wake into stacking");
        @(posedge sys_clk);
        #1;
        irqReq = 1'b0;
        repeat (30) @(posedge sys_clk);
        #1;
        t = findIdx(CYC_S, 16'h00FF);
        checkStack(t, 16'h0101, 8'h00, 8'h60, VEC_IRQ_LO, 16'h0300);
        checkRegs(8'h68, 16'h0000, 16'h00FA, 8'h60);
        endTest("wait wake");
    endtask

    // request held through reset: taken while the second opcode is pending
    task automatic testIrqExec();
        int t;
        clearMem();
        loadProg(16'h0100, '{8'h84, 8'h9F});
        loadProg(16'h0300, '{8'h85, 8'h8F});
        irqReq = 1'b1;
        startRun(7);
        irqReq = 1'b0;
        repeat (30) @(posedge sys_clk);
        #1;
        t = findIdx(CYC_S, 16'h00FF);
        checkStack(t, 16'h0101, 8'h00, 8'h60, VEC_IRQ_LO, 16'h0300);
        checkRegs(8'h68, 16'h0000, 16'h00FA, 8'h60);
        endTest("irq in flight");
    endtask

    task automatic testBranch();
        clearMem();
        loadProg(16'h0100, '{8'h20, 8'h7F});
        loadProg(16'h0181, '{8'h20, 8'h80});
        loadProg(16'h0103, '{8'h8F});
        startRun(30);
        checkVal(16'(findIdx(CYC_P, 16'h0181) >= 0), 16'h0001, "forward limit target");
        checkVal(16'(findIdx(CYC_P, 16'h0103) >= 0), 16'h0001, "backward limit target");
        checkVal(16'(halted), 16'h0001, "halted at target");
        checkVal(progCounterOut, 16'h0105, "pc after wait");
        endTest("branch");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // seven short runs need well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        testCopies();
        testFlagsLoad();
        testStackIndex();
        testTrap();
        testWaitWake();
        testIrqExec();
        testBranch();
        print_verdict();
    end
endmodule // test_cpu_transfer_trap_instr_exec
